// ---- hw/ctrm_defs.svh ----
`ifndef CTRM_DEFS_SVH
`define CTRM_DEFS_SVH

// address map
`define CTRM_WIN_BASE 16'h2000
`define CTRM_WIN_STEP 16'h0080
`define CTRM_FIFO_BASE 16'h1800
`define CTRM_WIN_TAG 6'h08
`define CTRM_FIFO_TAG 10'h060

// register index within a unit window (byte offset = 4 * index)
`define CTRM_R_STATUS 5'h00
`define CTRM_R_MODE 5'h01
`define CTRM_R_PRESCALE 5'h02
`define CTRM_R_COUNT 5'h03
`define CTRM_R_RELOAD 5'h04
`define CTRM_R_CLK_DBNC 5'h05
`define CTRM_R_GATE_DBNC 5'h06
`define CTRM_R_PERIODS 5'h07
`define CTRM_R_CAP_HIGH 5'h08
`define CTRM_R_CAP_LOW 5'h09
`define CTRM_R_TIME_BASE 5'h0a
`define CTRM_R_IN_COUNT 5'h0b
`define CTRM_R_IN_LEVEL 5'h0c
`define CTRM_R_IN_DATA 5'h0d
`define CTRM_R_OUT_COUNT 5'h0e
`define CTRM_R_OUT_LEVEL 5'h0f
`define CTRM_R_OUT_DATA 5'h10
`define CTRM_R_IRQ_STATUS 5'h11
`define CTRM_R_IRQ_ENABLE 5'h12
`define CTRM_R_IRQ_CLEAR 5'h13
`define CTRM_R_SEQ_DATA 5'h14
`define CTRM_R_PATTERN_A 5'h15
`define CTRM_R_PATTERN_B 5'h16

// fixed patterns
`define CTRM_PATTERN_A 32'h01234567
`define CTRM_PATTERN_B 32'habcd0123

// control and mode fields
`define CTRM_CTL_EN 31
`define CTRM_CTL_IFE 30
`define CTRM_MODE_GATE 2

// status bit positions
`define CTRM_ST_EN 31
`define CTRM_ST_BUSY 30
`define CTRM_ST_LT0 29
`define CTRM_ST_GE0 28
`define CTRM_ST_GE1 27
`define CTRM_ST_IN0 26
`define CTRM_ST_GT0 25
`define CTRM_ST_IN1 24
`define CTRM_ST_GT1 23
`define CTRM_ST_IHL 22
`define CTRM_ST_ILH 21
`define CTRM_ST_GHL 20
`define CTRM_ST_GLH 19
`define CTRM_ST_OUT 18
`define CTRM_ST_IRQ 17
`define CTRM_ST_CAPH 16
`define CTRM_ST_CAPL 15
`define CTRM_ST_IFE 14
`define CTRM_ST_IFH 13
`define CTRM_ST_IFF 12
`define CTRM_ST_OFE 11
`define CTRM_ST_OFH 10
`define CTRM_ST_OFF 9

// interrupt condition bits
`define CTRM_IRQ_TC 0
`define CTRM_IRQ_CAP 1
`define CTRM_IRQ_INLVL 2
`define CTRM_IRQ_CMP0 3
`define CTRM_IRQ_BITS 4

// debounce time base: limits are in cycles of this rate
`define CTRM_DBNC_MHZ 40'd66
`define CTRM_CLK_MHZ 40'd25

`endif

// ---- hw/ctrm_pkg.sv ----
package ctrm_pkg;
  typedef enum logic [1:0] {
    CTRM_MODE_EVENT,
    CTRM_MODE_PERIOD,
    CTRM_MODE_TIMEBASE,
    CTRM_MODE_HOLD
  } ctrm_mode_t;
  typedef logic [31:0] ctrm_word_t;
endpackage

// ---- hw/ctrm_dbnc_if.sv ----
`timescale 1ns/10ps
interface ctrm_dbnc_if;
  logic raw;
  logic run;
  logic [31:0] limit;
  logic level;
  logic rise;
  logic fall;
  modport dev (input raw, input run, input limit,
               output level, output rise, output fall);
  modport user (output raw, output run, output limit,
                input level, input rise, input fall);
endinterface

// ---- hw/ctrm_debounce.sv ----
`timescale 1ns/10ps
`include "ctrm_defs.svh"
module ctrm_debounce
  import ctrm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // debounced line
  ctrm_dbnc_if.dev d
);
  logic level_r;
  logic rise_r;
  logic fall_r;
  logic [39:0] acc_r;
  logic [39:0] acc_nxt;
  logic [39:0] need;
  logic settled;

  // elapsed time kept in units of 1/25 of a 66 MHz cycle, so no rounding
  assign acc_nxt = acc_r + `CTRM_DBNC_MHZ;
  assign need = {8'h00, d.limit} * `CTRM_CLK_MHZ;
  assign settled = (acc_nxt >= need);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      acc_r <= 40'h0;
    end else begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      // frozen while the unit is disabled
      if (d.run) begin
        if (d.raw == level_r) begin
          acc_r <= 40'h0;
        end else if (settled) begin
          acc_r <= 40'h0;
          level_r <= d.raw;
          rise_r <= d.raw;
          fall_r <= ~d.raw;
        end else begin
          acc_r <= acc_nxt;
        end
      end
    end
  end

  assign d.level = level_r;
  assign d.rise = rise_r;
  assign d.fall = fall_r;
endmodule

// ---- hw/ctrm_bank.sv ----
`timescale 1ns/10ps
`include "ctrm_defs.svh"
// What this block does
// - eight units, each a 128-byte window from 0x2000, step 0x80.
// - shared fifo data locations sit at base plus 0x1800.
// - status register reads only; control register writes only.
// - write-only mode register selects counter and prescaler operation.
// - count register reads present count; writes are ignored.
// - reload write stores value and copies it into the count.
// - input clock edge accepted after stable for programmed 66 MHz cycles.
// - gate change accepted after stable for programmed 66 MHz cycles.
// - capture-high address reads capture high, writes compare zero.
// - capture-low address reads capture low, writes compare one.
// - write-only time base divides clock for time-based capture.
// - input fifo has count, threshold level, and write-only data port.
// - output fifo has count and read data port; level reserved.
// - interrupt status shows only enabled conditions.
// - interrupt raised only for conditions enabled.
// - clear write drops latched bits; persisting condition latches again.
// - first test register always reads 0x01234567.
// - second test register always reads 0xabcd0123.
// - sequencer data register is reserved, without function.
module ctrm_bank
  import ctrm_pkg::*;
#(
  parameter int UNITS = 8,
  parameter int FIFO_DEPTH = 16
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // counter pins
  input wire logic [UNITS-1:0] ext_clk_i,
  input wire logic [UNITS-1:0] ext_gate_i,
  output logic [UNITS-1:0] ext_out_o,
  output logic irq_o
);
  localparam int AW = $clog2(FIFO_DEPTH);

  if (UNITS != 8) begin : g_bad_units
    $error("bank must hold exactly eight units");
  end
  if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic ack_r;
  logic [31:0] dat_r;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic in_win;
  logic in_fifo_win;
  logic [2:0] unit_sel;
  logic [4:0] reg_idx;
  logic fifo_in_sel;
  logic [31:0] wmask;
  logic [31:0] unit_rdata [UNITS];
  logic [31:0] fifo_rdata [UNITS];
  logic [UNITS-1:0] unit_irq;

  assign req = cyc_i & stb_i & ~ack_r;
  // effects happen only at the edge that the master sees ack
  assign acc_wr = cyc_i & stb_i & ack_r & we_i;
  assign acc_rd = cyc_i & stb_i & ack_r & ~we_i;
  assign in_win = (adr_i[15:10] == `CTRM_WIN_TAG);
  assign in_fifo_win = (adr_i[15:6] == `CTRM_FIFO_TAG);
  assign unit_sel = in_win ? adr_i[9:7] : adr_i[5:3];
  assign reg_idx = adr_i[6:2];
  assign fifo_in_sel = ~adr_i[2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                  {8{sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req;
      if (req) begin
        if (we_i) begin
          dat_r <= 32'h0;
        end else if (in_win) begin
          dat_r <= unit_rdata[unit_sel];
        end else if (in_fifo_win) begin
          dat_r <= fifo_rdata[unit_sel];
        end else begin
          dat_r <= 32'h0;
        end
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign irq_o = |unit_irq;

  ////////////////////////////////////////////////////////////////////////////
  // counter units

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    ctrm_dbnc_if clk_db ();
    ctrm_dbnc_if gate_db ();

    logic [31:0] ctl_r;
    logic [31:0] mode_r;
    logic [31:0] div_r;
    logic [31:0] psc_r;
    logic [31:0] count_r;
    logic [31:0] reload_r;
    logic [31:0] clk_lim_r;
    logic [31:0] gate_lim_r;
    logic [31:0] periods_r;
    logic [31:0] per_seen_r;
    logic [31:0] cmp0_r;
    logic [31:0] cmp1_r;
    logic [31:0] cap_hi_r;
    logic [31:0] cap_lo_r;
    logic [31:0] tb_r;
    logic [31:0] tb_cnt_r;
    logic [31:0] in_lvl_r;
    logic [`CTRM_IRQ_BITS-1:0] ier_r;
    logic [`CTRM_IRQ_BITS-1:0] isr_r;
    logic [`CTRM_IRQ_BITS-1:0] cond;
    logic [3:0] edge_r;
    logic cap_h_ok_r;
    logic cap_l_ok_r;
    logic [31:0] in_mem [FIFO_DEPTH];
    logic [31:0] out_mem [FIFO_DEPTH];
    logic [AW:0] in_wp_r;
    logic [AW:0] in_rp_r;
    logic [AW:0] out_wp_r;
    logic [AW:0] out_rp_r;

    logic hit;
    logic fhit;
    logic wr_any;
    logic [31:0] wval;
    logic run;
    ctrm_mode_t mode;
    logic gate_ok;
    logic psc_tick;
    logic ev_tick;
    logic tc;
    logic per_done;
    logic tb_done;
    logic capture;
    logic [31:0] cap_word;
    logic [AW:0] in_used;
    logic [AW:0] out_used;
    logic in_full;
    logic in_empty;
    logic out_full;
    logic out_empty;
    logic in_push;
    logic in_pop;
    logic out_push;
    logic out_pop;
    logic st_rd;
    logic [31:0] status;
    logic [3:0] edge_now;
    logic [31:0] out_head;

    assign hit = in_win & (unit_sel == 3'(u));
    assign fhit = in_fifo_win & (unit_sel == 3'(u));
    assign wr_any = acc_wr & hit;
    assign wval = dat_i & wmask;
    assign run = ctl_r[`CTRM_CTL_EN];
    assign mode = ctrm_mode_t'(mode_r[1:0]);

    // debouncers freeze with the unit
    assign clk_db.raw = ext_clk_i[u];
    assign clk_db.run = run;
    assign clk_db.limit = clk_lim_r;
    assign gate_db.raw = ext_gate_i[u];
    assign gate_db.run = run;
    assign gate_db.limit = gate_lim_r;

    ctrm_debounce u_clk_db (.clk_i(clk_i), .rst_i(rst_i), .d(clk_db));
    ctrm_debounce u_gate_db (.clk_i(clk_i), .rst_i(rst_i), .d(gate_db));

    assign gate_ok = ~mode_r[`CTRM_MODE_GATE] | gate_db.level;
    assign psc_tick = clk_db.rise & gate_ok & (psc_r >= div_r);
    assign ev_tick = run & (mode == CTRM_MODE_EVENT) & psc_tick;
    assign tc = ev_tick & (count_r == 32'h0);
    // a zero period count is taken as one period
    assign per_done = run & (mode == CTRM_MODE_PERIOD) & psc_tick &
                      (per_seen_r + 32'h1 >= periods_r);
    assign tb_done = run & (mode == CTRM_MODE_TIMEBASE) &
                     (tb_cnt_r >= {1'b0, tb_r[30:0]});
    assign capture = per_done | tb_done;
    assign cap_word = count_r + 32'(per_done);

    // fifos
    assign in_used = in_wp_r - in_rp_r;
    assign out_used = out_wp_r - out_rp_r;
    assign in_full = (in_used == (AW+1)'(FIFO_DEPTH));
    assign in_empty = (in_used == '0);
    assign out_full = (out_used == (AW+1)'(FIFO_DEPTH));
    assign out_empty = (out_used == '0);
    // pushes onto a full fifo are dropped
    assign in_push = acc_wr & ~in_full &
                     ((hit & (reg_idx == `CTRM_R_IN_DATA)) |
                      (fhit & fifo_in_sel));
    assign in_pop = tc & ctl_r[`CTRM_CTL_IFE] & ~in_empty;
    assign out_push = capture & ~out_full;
    assign out_pop = acc_rd & ~out_empty &
                     ((hit & (reg_idx == `CTRM_R_OUT_DATA)) |
                      (fhit & ~fifo_in_sel));

    // interrupt conditions
    assign cond[`CTRM_IRQ_TC] = tc;
    assign cond[`CTRM_IRQ_CAP] = capture;
    assign cond[`CTRM_IRQ_INLVL] = ({{(31-AW){1'b0}}, in_used} <= in_lvl_r);
    assign cond[`CTRM_IRQ_CMP0] = run & (count_r == cmp0_r);
    assign unit_irq[u] = |(isr_r & ier_r);

    assign edge_now = {clk_db.fall, clk_db.rise, gate_db.fall, gate_db.rise};
    assign st_rd = acc_rd & hit & (reg_idx == `CTRM_R_STATUS);
    assign ext_out_o[u] = run & (count_r < cmp0_r);

    always_comb begin
      status = 32'h0;
      status[`CTRM_ST_EN] = run;
      status[`CTRM_ST_BUSY] = run & (count_r != 32'h0);
      status[`CTRM_ST_LT0] = count_r < cmp0_r;
      status[`CTRM_ST_GE0] = count_r >= cmp0_r;
      status[`CTRM_ST_GE1] = count_r >= cmp1_r;
      status[`CTRM_ST_IN0] = ext_clk_i[u];
      status[`CTRM_ST_GT0] = ext_gate_i[u];
      status[`CTRM_ST_IN1] = clk_db.level;
      status[`CTRM_ST_GT1] = gate_db.level;
      status[`CTRM_ST_IHL] = edge_r[3];
      status[`CTRM_ST_ILH] = edge_r[2];
      status[`CTRM_ST_GHL] = edge_r[1];
      status[`CTRM_ST_GLH] = edge_r[0];
      status[`CTRM_ST_OUT] = ext_out_o[u];
      status[`CTRM_ST_IRQ] = unit_irq[u];
      status[`CTRM_ST_CAPH] = cap_h_ok_r;
      status[`CTRM_ST_CAPL] = cap_l_ok_r;
      status[`CTRM_ST_IFE] = in_empty;
      status[`CTRM_ST_IFH] = in_used >= (AW+1)'(FIFO_DEPTH / 2);
      status[`CTRM_ST_IFF] = in_full;
      status[`CTRM_ST_OFE] = out_empty;
      status[`CTRM_ST_OFH] = out_used >= (AW+1)'(FIFO_DEPTH / 2);
      status[`CTRM_ST_OFF] = out_full;
    end

    // write-only and reserved locations read as zero
    always_comb begin
      case (reg_idx)
        `CTRM_R_STATUS: unit_rdata[u] = status;
        `CTRM_R_PRESCALE: unit_rdata[u] = psc_r;
        `CTRM_R_COUNT: unit_rdata[u] = count_r;
        `CTRM_R_PERIODS: unit_rdata[u] = periods_r;
        `CTRM_R_CAP_HIGH: unit_rdata[u] = cap_hi_r;
        `CTRM_R_CAP_LOW: unit_rdata[u] = cap_lo_r;
        `CTRM_R_IN_COUNT: unit_rdata[u] = 32'(in_used);
        `CTRM_R_OUT_COUNT: unit_rdata[u] = 32'(out_used);
        `CTRM_R_OUT_DATA: unit_rdata[u] = out_head;
        `CTRM_R_IRQ_STATUS: unit_rdata[u] = 32'(isr_r & ier_r);
        `CTRM_R_PATTERN_A: unit_rdata[u] = `CTRM_PATTERN_A;
        `CTRM_R_PATTERN_B: unit_rdata[u] = `CTRM_PATTERN_B;
        default: unit_rdata[u] = 32'h0;
      endcase
    end
    // an empty fifo reads zero, never unwritten storage
    assign out_head = out_empty ? 32'h0 : out_mem[out_rp_r[AW-1:0]];
    assign fifo_rdata[u] = fifo_in_sel ? 32'h0 : out_head;

    always_ff @(posedge clk_i) begin
      if (in_push) in_mem[in_wp_r[AW-1:0]] <= dat_i;
      if (out_push) out_mem[out_wp_r[AW-1:0]] <= cap_word;
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctl_r <= 32'h0;
        mode_r <= 32'h0;
        div_r <= 32'h0;
        clk_lim_r <= 32'h0;
        gate_lim_r <= 32'h0;
        periods_r <= 32'h0;
        cmp1_r <= 32'h0;
        tb_r <= 32'h0;
        in_lvl_r <= 32'h0;
        ier_r <= '0;
      end else if (wr_any) begin
        case (reg_idx)
          `CTRM_R_STATUS: ctl_r <= (ctl_r & ~wmask) | wval;
          `CTRM_R_MODE: mode_r <= (mode_r & ~wmask) | wval;
          `CTRM_R_PRESCALE: div_r <= (div_r & ~wmask) | wval;
          `CTRM_R_CLK_DBNC: clk_lim_r <= (clk_lim_r & ~wmask) | wval;
          `CTRM_R_GATE_DBNC: gate_lim_r <= (gate_lim_r & ~wmask) | wval;
          `CTRM_R_PERIODS: periods_r <= (periods_r & ~wmask) | wval;
          `CTRM_R_CAP_LOW: cmp1_r <= (cmp1_r & ~wmask) | wval;
          `CTRM_R_TIME_BASE: tb_r <= (tb_r & ~wmask) | wval;
          `CTRM_R_IN_LEVEL: in_lvl_r <= (in_lvl_r & ~wmask) | wval;
          `CTRM_R_IRQ_ENABLE: ier_r <= wval[`CTRM_IRQ_BITS-1:0];
          default: ier_r <= ier_r;
        endcase
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        psc_r <= 32'h0;
        count_r <= 32'h0;
        reload_r <= 32'h0;
        cmp0_r <= 32'h0;
        per_seen_r <= 32'h0;
        tb_cnt_r <= 32'h0;
        cap_hi_r <= 32'h0;
        cap_lo_r <= 32'h0;
        cap_h_ok_r <= 1'b0;
        cap_l_ok_r <= 1'b0;
        in_wp_r <= '0;
        in_rp_r <= '0;
        out_wp_r <= '0;
        out_rp_r <= '0;
      end else begin
        // prescaler counts qualified input edges
        if (clk_db.rise & gate_ok & run) begin
          psc_r <= psc_tick ? 32'h0 : psc_r + 32'h1;
        end
        if (wr_any & (reg_idx == `CTRM_R_RELOAD)) begin
          reload_r <= wval;
          count_r <= wval;
        end else if (ev_tick) begin
          count_r <= tc ? reload_r : count_r - 32'h1;
        end else if (run & (mode == CTRM_MODE_PERIOD)) begin
          count_r <= per_done ? 32'h0 : count_r + 32'h1;
        end else if (tb_done) begin
          count_r <= 32'h0;
        end
        if (per_done) begin
          per_seen_r <= 32'h0;
        end else if (run & (mode == CTRM_MODE_PERIOD) & psc_tick) begin
          per_seen_r <= per_seen_r + 32'h1;
        end
        if (tb_done | ~run | (mode != CTRM_MODE_TIMEBASE)) begin
          tb_cnt_r <= 32'h0;
        end else begin
          tb_cnt_r <= tb_cnt_r + 32'h1;
        end
        // result is visible only once all periods are seen
        if (capture) begin
          cap_hi_r <= per_done ? per_seen_r + 32'h1 : 32'h0;
          cap_lo_r <= cap_word;
        end
        // valid flags: a new capture wins over the read that clears
        cap_h_ok_r <= capture | (cap_h_ok_r & ~(acc_rd & hit &
                      (reg_idx == `CTRM_R_CAP_HIGH)));
        cap_l_ok_r <= capture | (cap_l_ok_r & ~(acc_rd & hit &
                      (reg_idx == `CTRM_R_CAP_LOW)));
        if (wr_any & (reg_idx == `CTRM_R_CAP_HIGH)) begin
          cmp0_r <= (cmp0_r & ~wmask) | wval;
        end else if (in_pop) begin
          cmp0_r <= in_mem[in_rp_r[AW-1:0]];
        end
        if (in_push) in_wp_r <= in_wp_r + 1'b1;
        if (in_pop) in_rp_r <= in_rp_r + 1'b1;
        if (out_push) out_wp_r <= out_wp_r + 1'b1;
        if (out_pop) out_rp_r <= out_rp_r + 1'b1;
      end
    end

    // sticky bits: new events win over clears
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        isr_r <= '0;
        edge_r <= 4'h0;
      end else begin
        if (wr_any & (reg_idx == `CTRM_R_IRQ_CLEAR)) begin
          isr_r <= (isr_r & ~wval[`CTRM_IRQ_BITS-1:0]) | cond;
        end else begin
          isr_r <= isr_r | cond;
        end
        edge_r <= (st_rd ? 4'h0 : edge_r) | edge_now;
      end
    end
  end
endmodule

// ---- tb/ctrm_bank_properties.sv ----
`timescale 1ns/10ps
`include "ctrm_defs.svh"
module ctrm_bank_properties
  import ctrm_pkg::*;
#(
  parameter int UNITS = 8
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // counter pins
  input wire logic [UNITS-1:0] ext_clk_i,
  input wire logic [UNITS-1:0] ext_gate_i,
  input wire logic [UNITS-1:0] ext_out_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // tracks which units have any interrupt enable bit set
  logic [UNITS-1:0] ier_nz_r;
  logic [UNITS-1:0] ier_nz_nxt;
  wire ier_wr = cyc_i && stb_i && ack_o && we_i
    && adr_i[15:10] == `CTRM_WIN_TAG
    && adr_i[6:2] == `CTRM_R_IRQ_ENABLE;
  always_comb begin
    ier_nz_nxt = ier_nz_r;
    if (ier_wr) begin
      ier_nz_nxt[adr_i[9:7]] = |(dat_i[3:0] & {4{sel_i[0]}});
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) ier_nz_r <= '0;
    else ier_nz_r <= ier_nz_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  sequence taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_req(logic [4:0] idx);
    taken ##0 (!we_i && adr_i[15:10] == `CTRM_WIN_TAG && adr_i[6:2] == idx);
  endsequence
  AST_ACK_NEXT: assert property (taken |=> ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_DAT_HOLD: assert property (!(cyc_i && stb_i && !ack_o) |=>
    $stable(dat_o)) else $error("read data moved between accesses");
  AST_PAT_A: assert property (rd_req(`CTRM_R_PATTERN_A) |=>
    ack_o && dat_o == `CTRM_PATTERN_A) else $error("pattern a wrong");
  AST_PAT_B: assert property (rd_req(`CTRM_R_PATTERN_B) |=>
    ack_o && dat_o == `CTRM_PATTERN_B) else $error("pattern b wrong");
  AST_MODE_WO: assert property (rd_req(`CTRM_R_MODE) |=>
    dat_o == 32'h0) else $error("mode register readable");
  AST_UNMAPPED: assert property (taken ##0 (!we_i && adr_i[15:12] == 4'h0)
    |=> dat_o == 32'h0) else $error("unmapped read not zero");
  AST_IRQ_MASK: assert property (ier_nz_r == '0 |-> !irq_o)
    else $error("interrupt with nothing enabled");
endmodule

bind ctrm_bank ctrm_bank_properties #(.UNITS(UNITS)) u_ctrm_bank_properties (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_clk_i(ext_clk_i), .ext_gate_i(ext_gate_i), .ext_out_o(ext_out_o),
  .irq_o(irq_o));

// ---- tb/ctrm_pin_model.sv ----
`timescale 1ns/10ps
module ctrm_pin_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commands
  input wire logic start_i,
  input wire logic [2:0] unit_i,
  input wire logic [7:0] len_i,
  input wire logic [7:0] gate_i,
  // lines into the bank
  output logic [7:0] ext_clk_o,
  output logic [7:0] ext_gate_o
);
  logic [7:0] left_r;
  logic [2:0] unit_r;
  // one high pulse of len_i cycles; count lines idle low between pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_r <= 8'h00;
      unit_r <= 3'h0;
    end else if (start_i) begin
      left_r <= len_i;
      unit_r <= unit_i;
    end else if (left_r != 8'h00) left_r <= left_r - 8'h01;
  end
  assign ext_clk_o = (left_r != 8'h00) ? (8'h01 << unit_r) : 8'h00;
  assign ext_gate_o = gate_i;
endmodule

// ---- tb/ctrm_bank_test.sv ----
`timescale 1ns/10ps
`include "ctrm_defs.svh"
module ctrm_bank_test
  import ctrm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic [7:0] eclk;
  logic [7:0] egate;
  logic [7:0] eout;
  logic irq;
  logic start = 1'b0;
  logic [2:0] unit = 3'h0;
  logic [7:0] len = 8'h00;
  logic [7:0] gate = 8'h00;
  logic [31:0] q;
  int err_count = 0;
  int n_checks = 0;
  logic [4:0] wo [9] = '{`CTRM_R_MODE, `CTRM_R_RELOAD, `CTRM_R_CLK_DBNC,
    `CTRM_R_GATE_DBNC, `CTRM_R_TIME_BASE, `CTRM_R_IN_LEVEL,
    `CTRM_R_OUT_LEVEL, `CTRM_R_SEQ_DATA, `CTRM_R_IRQ_ENABLE};

  ctrm_bank #(.UNITS(8), .FIFO_DEPTH(16)) u_ctrm_bank (.clk_i(clk),
    .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .ext_clk_i(eclk), .ext_gate_i(egate), .ext_out_o(eout), .irq_o(irq));
  ctrm_pin_model u_ctrm_pin_model (.clk_i(clk), .rst_i(rst),
    .start_i(start), .unit_i(unit), .len_i(len), .gate_i(gate),
    .ext_clk_o(eclk), .ext_gate_o(egate));

  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle; the bench checks an answer latency of two clocks
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("ack latency", n, 32'd2);
    @(posedge clk);
  endtask

  function automatic logic [15:0] ra(input int u, input logic [4:0] i);
    return `CTRM_WIN_BASE + 16'(u) * `CTRM_WIN_STEP + {9'h0, i, 2'b00};
  endfunction

  task automatic pin(input logic [2:0] u, input logic [7:0] n);
    start <= 1'b1;
    unit <= u;
    len <= n;
    @(posedge clk);
    start <= 1'b0;
    repeat (int'(n) + 16) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    chk("watchdog", 32'h1, 32'h0);
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int u = 0; u < 8; u++) begin
      bus(0, ra(u, `CTRM_R_PATTERN_A), 32'h0);
      chk("pattern a", q, `CTRM_PATTERN_A);
      bus(0, ra(u, `CTRM_R_PATTERN_B), 32'h0);
      chk("pattern b", q, `CTRM_PATTERN_B);
      bus(0, ra(u, `CTRM_R_PRESCALE), 32'h0);
      chk("prescale reset", q, 32'h0);
    end
    $display("test map done");
    foreach (wo[i]) begin
      bus(1, ra(5, wo[i]), 32'ha5a50000);
      bus(0, ra(5, wo[i]), 32'h0);
      chk("write-only read", q, 32'h0);
    end
    bus(0, ra(5, `CTRM_R_COUNT), 32'h0);
    chk("count after reload", q, 32'ha5a50000);
    bus(1, 16'h0400, 32'hffffffff);
    bus(0, 16'h0400, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test access kinds done");
    bus(1, ra(2, `CTRM_R_RELOAD), 32'h32);
    bus(1, ra(2, `CTRM_R_COUNT), 32'hffffffff);
    bus(0, ra(2, `CTRM_R_COUNT), 32'h0);
    chk("count read only", q, 32'h32);
    bus(1, ra(2, `CTRM_R_CAP_HIGH), 32'h64);
    bus(1, ra(2, `CTRM_R_CAP_LOW), 32'h28);
    bus(0, ra(2, `CTRM_R_CAP_HIGH), 32'h0);
    chk("capture high", q, 32'h0);
    bus(0, ra(2, `CTRM_R_STATUS), 32'h0);
    chk("compare flags", q & 32'h38000000, 32'h28000000);
    bus(1, ra(2, `CTRM_R_STATUS), 32'h80000000);
    chk("out pin", {31'h0, eout[2]}, 32'h1);
    bus(1, ra(2, `CTRM_R_PERIODS), 32'h5);
    bus(0, ra(2, `CTRM_R_PERIODS), 32'h0);
    chk("period count", q, 32'h5);
    bus(1, ra(2, `CTRM_R_PRESCALE), 32'h3);
    bus(0, ra(2, `CTRM_R_PRESCALE), 32'h0);
    chk("live prescaler", q, 32'h0);
    $display("test compare done");
    // limit 8 at 66 MHz needs 4 clocks here, so 3 high clocks are a glitch
    bus(1, ra(1, `CTRM_R_CLK_DBNC), 32'h8);
    bus(1, ra(1, `CTRM_R_RELOAD), 32'ha);
    bus(1, ra(1, `CTRM_R_STATUS), 32'h80000000);
    pin(1, 8'd3);
    bus(0, ra(1, `CTRM_R_COUNT), 32'h0);
    chk("glitch ignored", q, 32'ha);
    pin(1, 8'd8);
    bus(0, ra(1, `CTRM_R_COUNT), 32'h0);
    chk("edge counted", q, 32'h9);
    bus(1, ra(1, `CTRM_R_GATE_DBNC), 32'h8);
    bus(1, ra(1, `CTRM_R_MODE), 32'h4);
    gate <= 8'h02;
    repeat (3) @(posedge clk);
    gate <= 8'h00;
    pin(1, 8'd8);
    bus(0, ra(1, `CTRM_R_STATUS), 32'h0);
    chk("gate glitch", q & 32'h00800000, 32'h0);
    bus(0, ra(1, `CTRM_R_COUNT), 32'h0);
    chk("gated count", q, 32'h9);
    gate <= 8'h02;
    repeat (16) @(posedge clk);
    pin(1, 8'd8);
    bus(0, ra(1, `CTRM_R_STATUS), 32'h0);
    chk("gate held", q & 32'h00800000, 32'h00800000);
    bus(0, ra(1, `CTRM_R_COUNT), 32'h0);
    chk("gate open count", q, 32'h8);
    bus(1, ra(6, `CTRM_R_PERIODS), 32'h2);
    bus(1, ra(6, `CTRM_R_MODE), 32'h1);
    bus(1, ra(6, `CTRM_R_STATUS), 32'h80000000);
    pin(6, 8'd4);
    bus(0, ra(6, `CTRM_R_CAP_HIGH), 32'h0);
    chk("result before periods", q, 32'h0);
    pin(6, 8'd4);
    bus(0, ra(6, `CTRM_R_CAP_HIGH), 32'h0);
    chk("periods averaged", q, 32'h2);
    bus(0, ra(6, `CTRM_R_OUT_COUNT), 32'h0);
    chk("capture queued", q, 32'h1);
    $display("test debounce done");
    bus(1, ra(3, `CTRM_R_IRQ_ENABLE), 32'h4);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(1, ra(3, `CTRM_R_IRQ_CLEAR), 32'h4);
    bus(0, ra(3, `CTRM_R_IRQ_STATUS), 32'h0);
    chk("irq relatched", q, 32'h4);
    bus(1, 16'h1818, 32'h11);
    bus(0, ra(3, `CTRM_R_IN_COUNT), 32'h0);
    chk("in fifo count", q, 32'h1);
    bus(1, ra(3, `CTRM_R_IRQ_CLEAR), 32'h4);
    bus(0, ra(3, `CTRM_R_IRQ_STATUS), 32'h0);
    chk("irq cleared", q, 32'h0);
    chk("irq line low", {31'h0, irq}, 32'h0);
    bus(0, 16'h181c, 32'h0);
    chk("empty pop", q, 32'h0);
    bus(0, ra(3, `CTRM_R_OUT_COUNT), 32'h0);
    chk("out fifo empty", q, 32'h0);
    $display("test interrupt done");
    final_report();
  end
endmodule
